// [core/pas_defs.vh]
/*
 * Constants for the port analog selection block: register offsets,
 * implemented-bit masks, reset values and the port width.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
// Functional notes
// - select bit 1: analog, digital read off
// - select bit 0: digital, digital read on
// - digital input valid one instruction cycle later
// - implemented select bits read/write, reset to 1
// - unimplemented bits ignore writes, read 0
// - port A implements bits 7:6 only
// - port A bits absent on small packages
// - port B implements all sixteen bits
// - port C bit 4 only, large package
// - port D implements bits 11:10
// - port D also implements bits 7:6
// - analog-input pins read 0 in pin value
// - direction 1 is input, reset to input
`ifndef PAS_DEFS_VH
`define PAS_DEFS_VH

// ==========================================================
// register byte offsets
`define PAS_OFS_SEL_A 6'h00
`define PAS_OFS_SEL_B 6'h04
`define PAS_OFS_SEL_C 6'h08
`define PAS_OFS_SEL_D 6'h0C
`define PAS_OFS_DIR_A 6'h10
`define PAS_OFS_DIR_B 6'h14
`define PAS_OFS_DIR_C 6'h18
`define PAS_OFS_DIR_D 6'h1C
`define PAS_OFS_PIN_A 6'h20
`define PAS_OFS_PIN_B 6'h24
`define PAS_OFS_PIN_C 6'h28
`define PAS_OFS_PIN_D 6'h2C

// ==========================================================
// implemented select bits
`define PAS_MASK_A_FULL 16'h00C0
`define PAS_MASK_B 16'hFFFF
`define PAS_MASK_C_FULL 16'h0010
`define PAS_MASK_D 16'h0CC0
`define PAS_MASK_NONE 16'h0000

// ==========================================================
// reset values and widths
`define PAS_SEL_RST 16'hFFFF
`define PAS_DIR_RST 16'hFFFF
`define PAS_PORT_W 16

`endif

// [core/pas_top.v]
/*
 * Port analog selection block: four analog select registers, four
 * direction registers and four pin value read ports on classic Wishbone.
 * Assumes pin inputs synchronous to core_clk; one core_clk is one
 * instruction cycle.
 */
`timescale 1ns/1ps
`include "pas_defs.vh"

module pas_top #(
   parameter LARGE_PKG = 1
) (
   // clock, reset, enable
   input wire core_clk,
   input wire rstn,
   input wire clk_en,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   output wire wb_err_o,
   // pins, ports A..D packed {D,C,B,A}
   input wire [63:0] pin_in,
   output wire [63:0] analog_mode,
   output wire [63:0] pin_dir_in,
   output wire [63:0] dig_in_en
);

   localparam W = `PAS_PORT_W;
   // port A and C bits only exist on the largest package
   localparam [15:0] MASK_A = LARGE_PKG ? `PAS_MASK_A_FULL
                                        : `PAS_MASK_NONE;
   localparam [15:0] MASK_C = LARGE_PKG ? `PAS_MASK_C_FULL
                                        : `PAS_MASK_NONE;
   localparam [63:0] SEL_MASK = {`PAS_MASK_D, MASK_C, `PAS_MASK_B,
                                 MASK_A};

   // ==========================================================
   // address decode
   function [3:0] reg_index;
      input [5:0] adr;
      begin
         reg_index = {2'b00, adr[5:4]} * 4'h4 + {2'b00, adr[3:2]};
      end
   endfunction

   // per-port registers gathered here so each bit has a single driver
   wire [63:0] sel_all;
   wire [63:0] dir_all;
   reg [63:0] pin_q;
   reg ack_q;
   wire req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire [3:0] idx = reg_index(wb_adr_i);
   wire mapped = (idx < 4'hC) & (wb_adr_i[1:0] == 2'b00);
   wire wr = req & wb_we_i & mapped & clk_en;
   reg err_q;

   assign wb_ack_o = ack_q;
   assign wb_err_o = err_q;

   // ==========================================================
   // select and direction registers
   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : g_port
         wire [15:0] m = SEL_MASK[p*W +: W];
         wire [15:0] lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
         reg [15:0] sel_q;
         reg [15:0] dir_q;
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               sel_q <= `PAS_SEL_RST & m;
               dir_q <= `PAS_DIR_RST;
            end else if (wr && idx == p) begin
               // only implemented bits take the write
               sel_q <= (sel_q & ~(m & lane)) |
                  (wb_dat_i[15:0] & m & lane);
            end else if (wr && idx == p + 4) begin
               dir_q <= (dir_q & ~lane) |
                  (wb_dat_i[15:0] & lane);
            end
         end
         assign sel_all[p*W +: W] = sel_q;
         assign dir_all[p*W +: W] = dir_q;
      end
   endgenerate

   // ==========================================================
   // digital read path
   assign analog_mode = sel_all;
   assign dig_in_en = ~sel_all;
   assign pin_dir_in = dir_all;

   // sampled pins; one cycle settle after a config change
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pin_q <= 64'h0;
      end else if (clk_en) begin
         pin_q <= pin_in & ~sel_all;
      end
   end

   // ==========================================================
   // bus answer, one cycle after request
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (clk_en) begin
         ack_q <= req & mapped;
         err_q <= req & ~mapped;
         wb_dat_o <= 32'h0;
         if (req && mapped && !wb_we_i) begin
            case (idx[3:2])
               2'b00: wb_dat_o <= {16'h0000,
                  sel_all[idx[1:0]*W +: W]};
               2'b01: wb_dat_o <= {16'h0000, dir_all[idx[1:0]*W +: W]};
               2'b10: wb_dat_o <= {16'h0000, pin_q[idx[1:0]*W +: W]};
               default: wb_dat_o <= 32'h0;
            endcase
         end
      end else begin
         ack_q <= 1'b0;
         err_q <= 1'b0;
      end
   end

endmodule // pas_top

// [dv/pas_monitor.sv]
/* Checker on pas_top ports. Assumes the large package. */
`timescale 1ns/1ps
module pas_monitor (
   // watched ports
   input wire core_clk,
   input wire rstn,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_ack_o,
   input wire wb_err_o,
   input wire [63:0] analog_mode,
   input wire [63:0] dig_in_en
);
   localparam [63:0] msk = 64'h0CC00010FFFF00C0;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
   ack_next_a: assert property (req_s |=> wb_ack_o ^ wb_err_o)
      else $error("no answer");
   ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("long ack");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
      else $error("stray ack");
   no_both_a: assert property (!(wb_ack_o && wb_err_o))
      else $error("both");
   read_path_a: assert property (dig_in_en == ~analog_mode)
      else $error("read path");
   impl_bits_a: assert property ((analog_mode & ~msk) == 64'h0)
      else $error("unimpl bit");
   reset_val_a: assert property ($rose(rstn) |-> analog_mode == msk)
      else $error("reset");
   sel_hold_a: assert property (
      $changed(analog_mode) |-> $rose(wb_ack_o)) else $error("stray write");
endmodule // pas_monitor
bind pas_top pas_monitor i_mon (.core_clk(core_clk), .rstn(rstn),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .analog_mode(analog_mode), .dig_in_en(dig_in_en));

// [dv/tb.sv]
/* Bench for pas_top: bus traffic and pin reads. */
`timescale 1ns/1ps
module tb;
   reg core_clk = 1'h0, rstn = 1'h0;
   reg [23:0] req = 24'h0;
   reg [63:0] pins = {$urandom(32'h56A6), $urandom};
   reg [63:0] msk = 64'h0CC00010FFFF00C0;
   reg [16:0] q[$], v, r;
   wire [31:0] rdat;
   wire ack, err;
   integer mismatches = 0, compares = 0, i;
   always #2.5 core_clk = ~core_clk;
   pas_top i_dut (.core_clk(core_clk), .rstn(rstn), .clk_en(1'h1),
      .wb_cyc_i(req[23]), .wb_stb_i(req[23]), .wb_we_i(req[22]),
      .wb_adr_i(req[21:16]), .wb_sel_i(4'hF), .wb_dat_i({16'h0, req[15:0]}),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .pin_in(pins),
      .analog_mode(), .pin_dir_in(), .dig_in_en());
   task print_verdict;
      if (mismatches == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task acc(input w, input [5:0] a, input [15:0] d, input [16:0] e);
      q.push_back(e);
      req <= {1'h1, w, a, d};
      do @(posedge core_clk); while (!(ack | err));
      req[23] <= 1'h0;
      @(posedge core_clk);
   endtask
   always @(posedge core_clk) if (ack | err) begin
      v = q.pop_front();
      compares = compares + 1;
      if (err !== v[16] || (!req[22] && rdat !== {16'h0, v[15:0]})) begin
         mismatches = mismatches + 1;
         $display("mismatch %0t %h %h", $time, {err, rdat}, v);
      end
   end
   initial #20000 begin
      mismatches = mismatches + 1;
      print_verdict;
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rstn <= 1'h1;
      for (i = 0; i < 4; i = i + 1) begin
         acc(1'h0, 6'(4*i), 16'h0, {1'h0, msk[16*i+:16]});
         acc(1'h0, 6'(16+4*i), 16'h0, 17'h0FFFF);
         r = {1'h0, 16'($urandom)};
         acc(1'h1, 6'(4*i), r[15:0], 17'h0);
         // same value to direction: analog pins get 1/1, outputs 0/0
         acc(1'h1, 6'(16+4*i), r[15:0], 17'h0);
         acc(1'h0, 6'(16+4*i), 16'h0, r);
         r = r & {1'h0, msk[16*i+:16]};
         acc(1'h0, 6'(4*i), 16'h0, r);
         acc(1'h0, 6'(32+4*i), 16'h0, {1'h0, pins[16*i+:16] & ~r[15:0]});
      end
      acc(1'h1, 6'h30, 16'h0, 17'h10000);
      print_verdict;
   end
endmodule // tb
